// [include/ust_pkg.sv]
// Package with register map, field layout, reset values and state codes of the serial transmitter
package ust_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_DATA   = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_CTRL   = 5'h08;
  localparam logic [4:0] ADDR_FORMAT = 5'h0c;
  localparam logic [4:0] ADDR_BAUD   = 5'h10;

  // Status bit positions
  localparam int ST_BUF_EMPTY = 0;
  localparam int ST_TX_DONE   = 1;
  localparam int ST_TX_BUSY   = 2;
  localparam int ST_RX_DONE   = 3;
  localparam int ST_FRAME_ERR = 4;

  // Control bit positions
  localparam int CT_TX_EN  = 0;
  localparam int CT_RX_EN  = 1;
  localparam int CT_NINTH  = 2;
  localparam int CT_DOUBLE = 3;

  // Format field positions
  localparam int FM_SIZE_LO = 0;
  localparam int FM_PAR_LO  = 3;
  localparam int FM_STOP2   = 5;
  localparam int FM_CPOL    = 6;
  localparam int FM_SYNC    = 7;
  localparam int FM_SLAVE   = 8;

  // Reset values
  localparam logic [2:0]  RST_CHAR_SIZE = 3'h3;
  localparam logic [11:0] RST_DIVISOR   = 12'h000;

  // Character size codes
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_8 = 3'h3;
  localparam logic [2:0] SIZE_9 = 3'h7;

  // Baud ticks per bit, last index of the prescaler
  localparam logic [3:0] PRE_LAST_NORMAL = 4'hf;
  localparam logic [3:0] PRE_LAST_DOUBLE = 4'h7;

  typedef enum logic [2:0] {
    FR_IDLE   = 3'b000,
    FR_START  = 3'b001,
    FR_DATA   = 3'b010,
    FR_PARITY = 3'b011,
    FR_STOP1  = 3'b100,
    FR_STOP2  = 3'b101
  } ust_frame_e;

endpackage

// [core/ust_usart_tx.sv]
// Serial port transmitter with shared frame format, asynchronous and synchronous receive path and Avalon-MM registers
`timescale 1ns/1ps
module ust_usart_tx (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial pins
  output logic             serial_tx_pin,
  output logic             serial_tx_oe,
  input  wire logic        serial_rx_pin,
  // Transfer clock pin
  input  wire logic        transfer_clock_pin_i,
  output logic             transfer_clock_pin_o,
  output logic             transfer_clock_pin_oe
);

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
    logic                tx_en;
    logic                rx_en;
    logic                ninth;
    logic                dbl;
    logic [2:0]          csize;
    logic [1:0]          par_mode;
    logic                stop2;
    logic                cpol;
    logic                sync;
    logic                slave;
    logic [11:0]         divisor;
    logic [11:0]         bcnt;
    logic [8:0]          buf_data;
    logic                buf_full;
    logic                tx_enable_bit_eff;
    logic                txc;
    ust_pkg::ust_frame_e tx_st;
    logic [8:0]          tx_sh;
    logic                tx_par;
    logic [3:0]          tx_cnt;
    logic [3:0]          tx_pre;
    logic                tx_line;
    logic                xck_o;
    logic                xck_oe;
    logic                xck_prev;
    ust_pkg::ust_frame_e rx_st;
    logic [3:0]          rx_pre;
    logic [3:0]          rx_cnt;
    logic [8:0]          rx_sh;
    logic [8:0]          rx_data;
    logic                rx_complete_flag;
    logic                fe;
  } ust_state_s;

  ust_state_s s_reg;
  ust_state_s s_next;

  logic       baud_tick;
  logic [3:0] pre_last;
  logic [3:0] nbits;
  logic [8:0] dmask;
  logic       par_en;
  logic       xck_cur;
  logic       rise;
  logic       fall;
  logic       chg_edge;
  logic       smp_edge;
  logic       tx_tick;
  logic       rx_smp;
  logic       rx_start;
  logic       wr;
  logic       fin;
  logic [8:0] load_data;
  logic [31:0] rd_val;

  always_comb begin
    s_next    = s_reg;
    fin       = 1'b0;
    rd_val    = 32'h0000_0000;
    // one format for tx and rx
    // size code to data bit count
    unique case (s_reg.csize)
      ust_pkg::SIZE_5: nbits = 4'h5;
      ust_pkg::SIZE_6: nbits = 4'h6;
      ust_pkg::SIZE_7: nbits = 4'h7;
      ust_pkg::SIZE_9: nbits = 4'h9;
      default:         nbits = 4'h8;
    endcase
    dmask     = 9'(({1'b0, 9'h1ff} >> (4'h9 - nbits)));
    par_en    = s_reg.par_mode[1];
    load_data = {s_reg.ninth, s_reg.buf_data[7:0]} & dmask;

    baud_tick = (s_reg.bcnt == 12'h000);
    s_next.bcnt = baud_tick ? s_reg.divisor : s_reg.bcnt - 12'h001;
    pre_last = s_reg.dbl ? ust_pkg::PRE_LAST_DOUBLE : ust_pkg::PRE_LAST_NORMAL;

    // master drives clock pin, slave follows it
    if (s_reg.sync && !s_reg.slave && baud_tick) begin
      s_next.xck_o = ~s_reg.xck_o;
    end
    s_next.xck_oe   = s_reg.sync & ~s_reg.slave & (s_reg.tx_enable_bit_eff | s_reg.rx_en);
    xck_cur         = s_reg.slave ? transfer_clock_pin_i : s_reg.xck_o;
    s_next.xck_prev = xck_cur;
    rise            = xck_cur & ~s_reg.xck_prev;
    fall            = ~xck_cur & s_reg.xck_prev;
    chg_edge = s_reg.cpol ? fall : rise;
    smp_edge = s_reg.cpol ? rise : fall;

    // divide by 16 or 8, sync by 2
    if (baud_tick) begin
      s_next.tx_pre = (s_reg.tx_pre == pre_last) ? 4'h0 : s_reg.tx_pre + 4'h1;
    end
    tx_tick = s_reg.sync ? chg_edge : (baud_tick && s_reg.tx_pre == pre_last);

    // Transmit frame engine
    if (!s_reg.tx_enable_bit_eff) begin
      s_next.tx_line = 1'b1;
      s_next.tx_st   = ust_pkg::FR_IDLE;
    end else if (tx_tick) begin
      unique case (s_reg.tx_st)
        ust_pkg::FR_IDLE: begin
          s_next.tx_line = 1'b1;
          if (s_reg.buf_full) begin
            fin = 1'b1;
          end
        end
        ust_pkg::FR_START: begin
          s_next.tx_st   = ust_pkg::FR_DATA;
          s_next.tx_cnt  = 4'h0;
          s_next.tx_line = s_reg.tx_sh[0];
        end
        ust_pkg::FR_DATA: begin
          if (s_reg.tx_cnt == nbits - 4'h1) begin
            s_next.tx_st   = par_en ? ust_pkg::FR_PARITY : ust_pkg::FR_STOP1;
            s_next.tx_line = par_en ? s_reg.tx_par : 1'b1;
          end else begin
            s_next.tx_cnt  = s_reg.tx_cnt + 4'h1;
            s_next.tx_line = s_reg.tx_sh[s_reg.tx_cnt + 4'h1];
          end
        end
        ust_pkg::FR_PARITY: begin
          s_next.tx_st   = ust_pkg::FR_STOP1;
          s_next.tx_line = 1'b1;
        end
        ust_pkg::FR_STOP1: begin
          if (s_reg.stop2) begin
            s_next.tx_st = ust_pkg::FR_STOP2;
          end else begin
            fin = 1'b1;
          end
        end
        ust_pkg::FR_STOP2: begin
          fin = 1'b1;
        end
        default: begin
          s_next.tx_st = ust_pkg::FR_IDLE;
        end
      endcase
      if (fin) begin
        if (s_reg.buf_full) begin
          s_next.tx_sh    = load_data;
          s_next.tx_par   = (^load_data) ^ s_reg.par_mode[0];
          s_next.buf_full = 1'b0;
          s_next.tx_st    = ust_pkg::FR_START;
          s_next.tx_line  = 1'b0;
        end else begin
          s_next.tx_st   = ust_pkg::FR_IDLE;
          s_next.tx_line = 1'b1;
          if (s_reg.tx_st != ust_pkg::FR_IDLE) begin
            s_next.txc = 1'b1;
          end
        end
      end
    end

    // disable waits for shifter and buffer
    s_next.tx_enable_bit_eff = s_reg.tx_en |
                      (s_reg.tx_enable_bit_eff & (s_reg.tx_st != ust_pkg::FR_IDLE | s_reg.buf_full));

    // Receive path, sampled opposite the change edge in sync mode, mid-bit by the prescaler in async mode
    if (baud_tick) begin
      s_next.rx_pre = (s_reg.rx_pre == pre_last) ? 4'h0 : s_reg.rx_pre + 4'h1;
    end
    rx_smp   = s_reg.sync ? smp_edge : (baud_tick && s_reg.rx_pre == pre_last);
    rx_start = s_reg.sync ? (smp_edge && !serial_rx_pin) :
               (baud_tick && s_reg.rx_pre == (pre_last >> 1) && !serial_rx_pin);
    if (!s_reg.rx_en) begin
      s_next.rx_st = ust_pkg::FR_IDLE;
    end else if (s_reg.rx_st == ust_pkg::FR_IDLE) begin
      if (!s_reg.sync && serial_rx_pin) begin
        s_next.rx_pre = 4'h0;
      end
      if (rx_start) begin
        s_next.rx_st  = ust_pkg::FR_DATA;
        s_next.rx_cnt = 4'h0;
        s_next.rx_sh  = 9'h000;
        s_next.rx_pre = 4'h0;
      end
    end else if (rx_smp) begin
      unique case (s_reg.rx_st)
        ust_pkg::FR_DATA: begin
          s_next.rx_sh[s_reg.rx_cnt] = serial_rx_pin;
          s_next.rx_cnt              = s_reg.rx_cnt + 4'h1;
          if (s_reg.rx_cnt == nbits - 4'h1) begin
            s_next.rx_st = par_en ? ust_pkg::FR_PARITY : ust_pkg::FR_STOP1;
          end
        end
        ust_pkg::FR_PARITY: begin
          s_next.rx_st = ust_pkg::FR_STOP1;
        end
        default: begin
          // only first stop checked, second ignored
          s_next.rx_data = s_reg.rx_sh;
          s_next.rx_complete_flag     = 1'b1;
          s_next.fe      = ~serial_rx_pin;
          s_next.rx_st   = ust_pkg::FR_IDLE;
        end
      endcase
    end

    // Avalon-MM: one wait cycle, write lands on the acknowledge edge
    s_next.ack = (avs_read | avs_write) & ~s_reg.ack;
    unique case (avs_address)
      ust_pkg::ADDR_DATA:   rd_val = {23'h000000, s_reg.rx_data};
      ust_pkg::ADDR_STATUS: rd_val = {27'h0000000, s_reg.fe, s_reg.rx_complete_flag,
                                      (s_reg.tx_st != ust_pkg::FR_IDLE), s_reg.txc, ~s_reg.buf_full};
      ust_pkg::ADDR_CTRL:   rd_val = {28'h0000000, s_reg.dbl, s_reg.ninth, s_reg.rx_en, s_reg.tx_en};
      ust_pkg::ADDR_FORMAT: rd_val = {23'h000000, s_reg.slave, s_reg.sync, s_reg.cpol, s_reg.stop2,
                                      s_reg.par_mode, s_reg.csize};
      ust_pkg::ADDR_BAUD:   rd_val = {20'h00000, s_reg.divisor};
      default:              rd_val = 32'h0000_0000;
    endcase
    if (avs_read && !s_reg.ack) begin
      s_next.rdata = rd_val;
    end
    // Data read clears receive done unless a frame lands now
    if (avs_read && s_reg.ack && avs_address == ust_pkg::ADDR_DATA && !(s_next.rx_complete_flag && !s_reg.rx_complete_flag)) begin
      s_next.rx_complete_flag = 1'b0;
    end
    wr = avs_write & s_reg.ack;
    if (wr) begin
      unique case (avs_address)
        ust_pkg::ADDR_DATA: begin
          // data write fills buffer, starts send
          // buffer empty flag drops on write
          s_next.buf_data = avs_writedata[8:0];
          s_next.buf_full = 1'b1;
        end
        ust_pkg::ADDR_STATUS: begin
          // write one clears, a new set wins
          if (avs_writedata[ust_pkg::ST_TX_DONE] && !(s_next.txc && !s_reg.txc)) begin
            s_next.txc = 1'b0;
          end
          if (avs_writedata[ust_pkg::ST_FRAME_ERR] && !(rx_smp && s_reg.rx_st == ust_pkg::FR_STOP1)) begin
            s_next.fe = 1'b0;
          end
        end
        ust_pkg::ADDR_CTRL: begin
          s_next.tx_en = avs_writedata[ust_pkg::CT_TX_EN];
          s_next.rx_en = avs_writedata[ust_pkg::CT_RX_EN];
          s_next.ninth = avs_writedata[ust_pkg::CT_NINTH];
          s_next.dbl   = avs_writedata[ust_pkg::CT_DOUBLE];
        end
        ust_pkg::ADDR_FORMAT: begin
          s_next.csize    = avs_writedata[ust_pkg::FM_SIZE_LO +: 3];
          s_next.par_mode = avs_writedata[ust_pkg::FM_PAR_LO +: 2];
          s_next.stop2    = avs_writedata[ust_pkg::FM_STOP2];
          s_next.cpol     = avs_writedata[ust_pkg::FM_CPOL];
          s_next.sync     = avs_writedata[ust_pkg::FM_SYNC];
          s_next.slave    = avs_writedata[ust_pkg::FM_SLAVE];
        end
        ust_pkg::ADDR_BAUD: begin
          // Divisor write restarts the baud counter
          s_next.divisor = avs_writedata[11:0];
          s_next.bcnt    = avs_writedata[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.csize    <= ust_pkg::RST_CHAR_SIZE;
      s_reg.divisor  <= ust_pkg::RST_DIVISOR;
      s_reg.bcnt     <= ust_pkg::RST_DIVISOR;
      s_reg.tx_line  <= 1'b1;
      s_reg.tx_st    <= ust_pkg::FR_IDLE;
      s_reg.rx_st    <= ust_pkg::FR_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata          = s_reg.rdata;
  assign avs_waitrequest       = ~s_reg.ack;
  assign serial_tx_pin         = s_reg.tx_line;
  assign serial_tx_oe          = s_reg.tx_enable_bit_eff;
  assign transfer_clock_pin_o  = s_reg.xck_o;
  assign transfer_clock_pin_oe = s_reg.xck_oe;

endmodule

// [bench/ust_peer.sv]
// Remote serial peer that samples transmitted frames at mid-bit
`timescale 1ns/1ps
module ust_peer (
  // Line from the transmitter
  input  wire logic   mclk,
  input  wire logic   txd,
  // Frame shape set by the bench
  input  wire logic   en,
  input  int          nbits,
  input  int          bitlen,
  // Lines back and capture
  output logic        rxd,
  output logic        xck,
  output logic [12:0] frame,
  output int          frames
);
  // Receive line rests at its pull-up level, clock input held low
  initial begin
    rxd = 1'b1;
    xck = 1'b0;
    frames = 0;
  end
  // start low, fixed bit count, stops high
  always begin
    @(negedge txd);
    if (en) begin
      frame = '1;
      for (int i = 0; i <= nbits; i++) begin
        repeat (i == 0 ? bitlen / 2 : bitlen) @(negedge mclk);
        frame[i] = txd;
      end
      frames++;
    end
  end
endmodule

// [bench/ust_assertions.sv]
// Checker for handshake, line levels and bit timing of the transmitter
`timescale 1ns/1ps
module ust_checker (
  // Clock, reset and register bus
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        serial_tx_pin,
  input wire logic        serial_tx_oe,
  input wire logic        transfer_clock_pin_o,
  input wire logic        transfer_clock_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [8:0]  fmt;
  logic [3:0]  ctl;
  logic [11:0] dv;
  logic        acc;
  logic        sm;
  int          run;
  int          blen;
  assign acc  = avs_write && !avs_waitrequest;
  assign sm   = fmt[7] && !fmt[8];
  assign blen = (int'(dv) + 1) * (ctl[3] ? 8 : 16);
  // Mirrored settings; only idle-time changes keep the bit grid valid
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fmt <= 9'h003;
      ctl <= 4'h0;
      dv <= 12'h000;
      run <= 0;
    end else begin
      run <= $changed(serial_tx_pin) ? 1 : run + 1;
      if (acc && avs_address == ust_pkg::ADDR_FORMAT) fmt <= avs_writedata[8:0];
      if (acc && avs_address == ust_pkg::ADDR_CTRL) ctl <= avs_writedata[3:0];
      if (acc && avs_address == ust_pkg::ADDR_BAUD) dv <= avs_writedata[11:0];
    end
  end
  wait_rise_a: assert property ($rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  pin_take_a: assert property ($rose(serial_tx_oe) |-> serial_tx_pin && ctl[0])
    else $error("pin taken without enable or not idle");
  bit_len_a: assert property ($rose(serial_tx_pin) && serial_tx_oe && !fmt[7] |-> run % blen == 0)
    else $error("low run not a whole number of bits");
  release_a: assert property ($fell(serial_tx_oe) |-> serial_tx_pin && $past(serial_tx_pin) && !ctl[0])
    else $error("pin released mid frame");
  pol_rise_a: assert property ($changed(serial_tx_pin) && sm && !fmt[6] |->
    $past(transfer_clock_pin_o) && !$past(transfer_clock_pin_o, 2))
    else $error("data not changed after rising clock");
  pol_fall_a: assert property ($changed(serial_tx_pin) && sm && fmt[6] |->
    !$past(transfer_clock_pin_o) && $past(transfer_clock_pin_o, 2))
    else $error("data not changed after falling clock");
  clk_drive_a: assert property ((sm && ctl[0]) [*3] |-> transfer_clock_pin_oe)
    else $error("transfer clock not driven");
  async_c: cover property ($fell(serial_tx_pin) && !fmt[7]);
  sync_c: cover property ($changed(serial_tx_pin) && sm && fmt[6]);
  release_c: cover property ($fell(serial_tx_oe));
endmodule
bind ust_usart_tx ust_checker chk_i (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_waitrequest, .serial_tx_pin, .serial_tx_oe, .transfer_clock_pin_o, .transfer_clock_pin_oe);

// [bench/tb_top.sv]
// Self-checking testbench for the serial frame transmitter
`timescale 1ns/1ps
module tb_top;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, serial_tx_pin, serial_tx_oe;
  logic        serial_rx_pin, transfer_clock_pin_i, pr_en, xck_oe;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [12:0] frame;
  int          error_cnt, compares, frames, pr_bits, pr_len;

  ust_usart_tx DUT (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .serial_tx_pin, .serial_tx_oe, .serial_rx_pin, .transfer_clock_pin_i,
    .transfer_clock_pin_o(), .transfer_clock_pin_oe(xck_oe));
  ust_peer peer (.mclk, .txd(serial_tx_pin), .en(pr_en), .nbits(pr_bits), .bitlen(pr_len),
    .rxd(serial_rx_pin), .xck(transfer_clock_pin_i), .frame, .frames);

  task automatic final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  task automatic wait_frm(input int tgt, output int c);
    c = 0;
    while (frames < tgt && c < 5000) begin
      @(posedge mclk);
      c++;
    end
    chk("frames", frames, tgt);
  endtask

  // Start low, data LSB first, parity, stops high
  function automatic logic [12:0] frm(int n, logic [1:0] p, logic [8:0] d);
    logic [12:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < n; k++) f[k + 1] = d[k];
    if (p[1]) f[n + 1] = ^(d & 9'((10'h1 << n) - 1)) ^ p[0];
    return f;
  endfunction

  task automatic s_reset;
    rc(ust_pkg::ADDR_FORMAT, 32'h3, "format");
    rc(ust_pkg::ADDR_STATUS, 32'h1, "status");
    rc(5'h14, 32'h0, "unmapped");
    chk("oe", serial_tx_oe, 1'b0);
    wr(ust_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    chk("oe", serial_tx_oe, 1'b1);
  endtask

  // Upper bits flipped to show they are ignored; ninth bit set before the low byte
  task automatic s_frame(input int n, input logic [1:0] p, input logic s2, input int dv, input logic db,
                         input logic [8:0] d);
    int c;
    pr_bits = n + p[1] + s2 + 1;
    pr_len = (dv + 1) * (db ? 8 : 16);
    wr(ust_pkg::ADDR_BAUD, dv);
    wr(ust_pkg::ADDR_FORMAT, {26'h0, s2, p, (n == 9) ? ust_pkg::SIZE_9 : 3'(n - 5)});
    wr(ust_pkg::ADDR_CTRL, {28'h0, db, d[8], 2'b01});
    wr(ust_pkg::ADDR_DATA, {24'h0, d[7:0] ^ (8'hff << n)});
    c = frames;
    wait_frm(c + 1, c);
    chk("frame", frame, frm(n, p, d));
    repeat (pr_len) @(posedge mclk);
    rc(ust_pkg::ADDR_STATUS, 32'h3, "status");
    wr(ust_pkg::ADDR_STATUS, 32'h2);
    rc(ust_pkg::ADDR_STATUS, 32'h1, "status");
  endtask

  task automatic s_sync;
    pr_en = 1'b0;
    wr(ust_pkg::ADDR_CTRL, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(ust_pkg::ADDR_FORMAT, 32'h83 | (p << 6));
      repeat (2) @(posedge mclk);
      chk("clock oe", xck_oe, 1'b1);
      wr(ust_pkg::ADDR_DATA, 32'h3c);
      repeat (60) @(posedge mclk);
      rc(ust_pkg::ADDR_STATUS, 32'h3, "sync status");
      wr(ust_pkg::ADDR_STATUS, 32'h2);
    end
    wr(ust_pkg::ADDR_FORMAT, 32'h3);
    pr_en = 1'b1;
  endtask

  // Second byte queued behind the first, then disable requested mid frame
  task automatic s_back;
    logic [31:0] q;
    int c, g;
    pr_bits = 9;
    pr_len = 16;
    wr(ust_pkg::ADDR_DATA, 32'h55);
    c = 0;
    // poll buffer empty before next write
    do begin
      bus(1'b0, ust_pkg::ADDR_STATUS, 32'h0, q);
      c++;
    end while (q[0] !== 1'b1 && c < 50);
    chk("buffer empty", q[0], 1'b1);
    wr(ust_pkg::ADDR_DATA, 32'haa);
    rc(ust_pkg::ADDR_STATUS, 32'h4, "status");
    wr(ust_pkg::ADDR_CTRL, 32'h0);
    c = frames;
    wait_frm(c + 1, g);
    chk("oe", serial_tx_oe, 1'b1);
    wait_frm(c + 2, g);
    chk("gap", g, 160);
    chk("frame", frame, frm(8, 2'b00, 9'h0aa));
    repeat (40) @(posedge mclk);
    chk("oe", serial_tx_oe, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    final_report;
  end

  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    pr_en = 1'b1;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset;
    s_frame(5, 2'b10, 1'b0, 0, 1'b0, 9'h013);
    s_frame(6, 2'b11, 1'b1, 1, 1'b1, 9'h02d);
    s_frame(7, 2'b00, 1'b0, 0, 1'b0, 9'h05a);
    s_frame(8, 2'b11, 1'b1, 0, 1'b1, 9'h0c3);
    s_frame(9, 2'b10, 1'b0, 0, 1'b0, 9'h1a5);
    s_sync;
    s_back;
    final_report;
  end
endmodule
